//--- shared/cia_pkg.sv
// Package: constants and carrier types for the core interrupt and addressing block
package cia_pkg;
   // ----------------
   // Sources, priorities and vectors
   // ----------------
   localparam int CIA_NSRC = 4;
   localparam logic [1:0] CIA_SRC_TRAP = 2'h0;
   localparam logic [1:0] CIA_SRC_TMR1 = 2'h1;
   localparam logic [1:0] CIA_SRC_TMR0 = 2'h2;
   localparam logic [1:0] CIA_SRC_WAKE = 2'h3;
   localparam logic [11:0] CIA_VEC_TMR0 = 12'hff6;
   localparam logic [11:0] CIA_VEC_TMR1 = 12'hff8;
   localparam logic [11:0] CIA_VEC_WAKE = 12'hffa;
   localparam logic [11:0] CIA_VEC_TRAP = 12'hffc;
   // ----------------
   // Stack and program counter
   // ----------------
   localparam logic [3:0] CIA_SP_RST = 4'hf;
   localparam logic [3:0] CIA_SP_STEP = 4'h2;
   localparam logic [7:0] CIA_STACK_BASE = 8'h30;
   localparam logic [11:0] CIA_PC_RST = 12'h800;
   localparam logic [11:0] CIA_PROG_BASE = 12'h800;
   // ----------------
   // Timing
   // ----------------
   localparam int CIA_ENTRY_CYCLES = 5;
   localparam logic [2:0] CIA_ENTRY_LAST = 3'(CIA_ENTRY_CYCLES - 1);
   localparam int CIA_REL_MIN = -31;
   localparam int CIA_REL_MAX = 32;
   // ----------------
   // Addressing modes
   // ----------------
   typedef enum logic [2:0] {
      CIA_AM_INDEXED = 3'h0,
      CIA_AM_INDIRECT = 3'h1,
      CIA_AM_DIRECT = 3'h2,
      CIA_AM_IMMEDIATE = 3'h3,
      CIA_AM_INHERENT = 3'h4,
      CIA_AM_ABSOLUTE = 3'h5,
      CIA_AM_RELATIVE = 3'h6
   } cia_mode_t;
   // Instruction classes that the mode checker needs to know about
   typedef enum logic [2:0] {
      CIA_OP_OTHER = 3'h0,
      CIA_OP_LESS_SKIP = 3'h1,
      CIA_OP_ACC_WRITE = 3'h2,
      CIA_OP_FAR_BRANCH = 3'h3,
      CIA_OP_CALL = 3'h4,
      CIA_OP_NEAR_BRANCH = 3'h5
   } cia_op_t;
   typedef struct packed {
      cia_op_t op;
      cia_mode_t mode;
      logic ptr_dest;
      logic [7:0] byte1;
      logic [7:0] byte2;
   } cia_addr_req_t;
   typedef struct packed {
      logic legal;
      logic is_value;
      logic prog_space;
      logic [11:0] addr;
      logic [7:0] value;
      logic [1:0] operand_bytes;
   } cia_addr_res_t;
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } cia_stack_wr_t;
   typedef enum logic [2:0] {
      CIA_ST_RUN = 3'h0,
      CIA_ST_ENTRY = 3'h1,
      CIA_ST_RET_LO = 3'h2,
      CIA_ST_RET_HI = 3'h3,
      CIA_ST_RET_GO = 3'h4
   } cia_state_t;
endpackage

//--- rtl/cia_addr_gen.sv
// Effective address former for the seven operand modes
`timescale 1ns/1ns
`default_nettype none
module cia_addr_gen
   import cia_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire cia_addr_req_t req_in,
   input wire logic [11:0] mem_ptr_in,
   input wire logic [11:0] pc_in,
   output cia_addr_res_t res_out
);
   typedef struct packed {
      cia_addr_res_t res;
   } cia_ag_state_t;
   cia_ag_state_t st_r;
   cia_ag_state_t st_nxt;
   logic [11:0] sum;
   logic signed [7:0] disp;
   always_comb begin
      st_nxt = '0;
      sum = 12'({1'b0, mem_ptr_in[10:0]} + {4'h0, req_in.byte1}); // RULE_11
      disp = $signed(req_in.byte1);
      st_nxt.res.legal = 1'b1;
      case (req_in.mode)
         CIA_AM_INDEXED: begin
            // Bit 11 of the pointer selects data or program space
            st_nxt.res.prog_space = mem_ptr_in[11]; // RULE_21
            st_nxt.res.addr = mem_ptr_in[11] ? (CIA_PROG_BASE | {1'b0, sum[10:0]})
                                              : {4'h0, sum[7:0]}; // RULE_11
            st_nxt.res.operand_bytes = 2'h1;
            st_nxt.res.legal = (req_in.op != CIA_OP_LESS_SKIP) && !req_in.ptr_dest; // RULE_18
         end
         CIA_AM_INDIRECT: begin
            st_nxt.res.addr = {4'h0, mem_ptr_in[7:0]}; // RULE_12
            st_nxt.res.legal = (req_in.op == CIA_OP_OTHER) || (req_in.op == CIA_OP_ACC_WRITE);
         end
         CIA_AM_DIRECT: begin
            st_nxt.res.addr = {4'h0, req_in.byte1}; // RULE_13
            st_nxt.res.operand_bytes = 2'h1;
            st_nxt.res.legal = (req_in.op == CIA_OP_OTHER) || (req_in.op == CIA_OP_ACC_WRITE);
         end
         CIA_AM_IMMEDIATE: begin
            st_nxt.res.is_value = 1'b1;
            st_nxt.res.value = req_in.byte1; // RULE_14
            st_nxt.res.operand_bytes = 2'h1;
            // Less-compare only against the pointer; stores have no value form
            st_nxt.res.legal = (req_in.op == CIA_OP_OTHER) ||
                               ((req_in.op == CIA_OP_LESS_SKIP) && req_in.ptr_dest); // RULE_18
         end
         CIA_AM_INHERENT: begin
            st_nxt.res.operand_bytes = 2'h0; // RULE_15
            st_nxt.res.legal = (req_in.op == CIA_OP_OTHER);
         end
         CIA_AM_ABSOLUTE: begin
            st_nxt.res.prog_space = 1'b1;
            st_nxt.res.addr = CIA_PROG_BASE | {1'b0, req_in.byte1[2:0], req_in.byte2}; // RULE_16
            st_nxt.res.operand_bytes = 2'h2;
            st_nxt.res.legal = (req_in.op == CIA_OP_FAR_BRANCH) ||
                               (req_in.op == CIA_OP_CALL); // RULE_16
         end
         CIA_AM_RELATIVE: begin
            st_nxt.res.prog_space = 1'b1;
            st_nxt.res.addr = 12'(pc_in + {{4{disp[7]}}, disp}); // RULE_17
            st_nxt.res.legal = (req_in.op == CIA_OP_NEAR_BRANCH) &&
                               (int'(disp) >= CIA_REL_MIN) && (int'(disp) <= CIA_REL_MAX); // RULE_17
         end
         default: st_nxt.res.legal = 1'b0;
      endcase
      if ((req_in.op == CIA_OP_FAR_BRANCH || req_in.op == CIA_OP_CALL) &&
          req_in.mode != CIA_AM_INDEXED && req_in.mode != CIA_AM_ABSOLUTE) begin
         st_nxt.res.legal = 1'b0; // RULE_18
      end
      if (req_in.op == CIA_OP_NEAR_BRANCH && req_in.mode != CIA_AM_RELATIVE) begin
         st_nxt.res.legal = 1'b0;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign res_out = st_r.res;
endmodule
`default_nettype wire

//--- rtl/cia_core_irq.sv
// Interrupt sequencer, stack traffic and operand address former for the core
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RULE_01 - Enable clear: requests just pend; enable set: pending maskable request is taken.
// RULE_02 - Reset clears enable; only a software set or return sets it.
// RULE_03 - Enable clears only after return address stacked and vector fetched.
// RULE_04 - Instruction in progress finishes before interrupt entry starts.
// RULE_05 - Entry pushes PC and jumps to vector, five cycles total.
// RULE_06 - Return pops address in reverse order, sets enable, resumes there.
// RULE_07 - Simultaneous requests: wake-up, timer zero, timer one, then trap.
// RULE_08 - Four sources; three hardware ones gated by enable, trap not gated.
// RULE_09 - Trap always enters, stacking PC and clearing enable like others.
// RULE_10 - Software may set enable inside a handler so interrupts nest.
// RULE_11 - Indexed: 8-bit unsigned offset plus pointer low eleven bits.
// RULE_12 - Indirect: pointer alone addresses data space.
// RULE_13 - Direct: 8-bit instruction field is the data address.
// RULE_14 - Immediate: 8-bit instruction field is the operand value.
// RULE_15 - Inherent: no operand bytes, opcode implies all.
// RULE_16 - Absolute: 11-bit program target from two bytes; far branch and call only.
// RULE_17 - Near branch adds operand to PC, range -31 to +32.
// RULE_18 - Only legal mode combinations are accepted by the decoder.
// RULE_19 - Return address low byte is pushed first.
// RULE_20 - Push lowers stack pointer by two, pull raises it by two.
// RULE_21 - Pointer bit 11 picks data or program space for indexed access.
// RULE_22 - Each source has its own two-byte vector; winner's vector loads PC.
// RULE_23 - Losing or masked requests stay pending and are served later.
module cia_core_irq
   import cia_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   // Request lines from peripherals, same clock domain
   input wire logic wakeup_edge_irq_in,
   input wire logic timer_zero_irq_in,
   input wire logic timer_one_irq_in,
   // Execution unit handshake
   input wire logic instr_done_in,
   input wire logic soft_trap_op_in,
   input wire logic irq_return_op_in,
   input wire logic enable_set_op_in,
   input wire logic enable_clr_op_in,
   input wire logic [11:0] pc_in,
   input wire logic [11:0] mem_ptr_in,
   // Stack memory read data, one cycle after the read address
   input wire logic [7:0] stack_rd_data_in,
   // Vector memory read data, one cycle after the vector address
   input wire logic [7:0] vec_rd_data_in,
   input wire cia_addr_req_t addr_req_in,
   output cia_addr_res_t addr_res_out,
   output logic irq_enable_out,
   output logic [3:0] pending_out,
   output logic busy_out,
   output logic hold_core_out,
   output logic [3:0] stack_ptr_out,
   output cia_stack_wr_t stack_wr_out,
   output logic [7:0] stack_rd_addr_out,
   output logic [11:0] vec_addr_out,
   output logic pc_load_out,
   output logic [11:0] pc_load_val_out,
   output logic [1:0] active_src_out
);
   // ----------------
   // State
   // ----------------
   typedef struct packed {
      cia_state_t state;
      logic enable;
      logic [3:0] pend;
      logic [1:0] src;
      logic [2:0] cyc;
      logic [3:0] sp;
      logic [11:0] ret_pc;
      logic [7:0] lo_byte;
      cia_stack_wr_t swr;
      logic [7:0] rd_addr;
      logic [11:0] vec_addr;
      logic pc_load;
      logic [11:0] pc_val;
   } cia_state_reg_t;
   cia_state_reg_t st_r;
   cia_state_reg_t st_nxt;
   logic rst_n;
   logic [3:0] req_now;
   logic [3:0] eligible;
   logic take;
   logic [1:0] win;
   logic [11:0] win_vec;
   // ----------------
   // Reset release
   // ----------------
   // Kept apart from the state struct: it runs on the raw reset, the struct on its copy
   logic [1:0] rst_sync_r;
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];
   // ----------------
   // Arbitration
   // ----------------
   always_comb begin
      req_now = st_r.pend | {wakeup_edge_irq_in, timer_zero_irq_in, timer_one_irq_in,
                             soft_trap_op_in};
      // Trap bypasses the enable, hardware sources do not
      eligible = {req_now[3:1] & {3{st_r.enable}}, req_now[0]}; // RULE_08 RULE_09 RULE_01
      win = CIA_SRC_TRAP;
      win_vec = CIA_VEC_TRAP;
      if (eligible[3]) begin // RULE_07
         win = CIA_SRC_WAKE;
         win_vec = CIA_VEC_WAKE; // RULE_22
      end else if (eligible[2]) begin
         win = CIA_SRC_TMR0;
         win_vec = CIA_VEC_TMR0;
      end else if (eligible[1]) begin
         win = CIA_SRC_TMR1;
         win_vec = CIA_VEC_TMR1;
      end
      // Entry only at an instruction boundary
      take = (st_r.state == CIA_ST_RUN) && instr_done_in && (eligible != 4'h0); // RULE_04
   end
   // ----------------
   // Sequencer
   // ----------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.swr = '0;
      st_nxt.pc_load = 1'b0;
      // Requests latch and stay until served
      st_nxt.pend = req_now; // RULE_23 RULE_01
      if (st_r.state == CIA_ST_RUN && irq_return_op_in) begin
         st_nxt.state = CIA_ST_RET_LO;
         st_nxt.sp = 4'(st_r.sp + CIA_SP_STEP); // RULE_20
         st_nxt.rd_addr = CIA_STACK_BASE | {4'h0, 4'(st_r.sp + 4'h1)}; // RULE_06
      end else if (take) begin
         st_nxt.state = CIA_ST_ENTRY;
         st_nxt.src = win;
         st_nxt.pend[win] = 1'b0;
         st_nxt.cyc = 3'h0;
         st_nxt.ret_pc = pc_in; // RULE_05
         st_nxt.vec_addr = win_vec; // RULE_22
      end else if (st_r.state == CIA_ST_RUN) begin
         if (enable_set_op_in) begin
            st_nxt.enable = 1'b1; // RULE_02 RULE_10
         end else if (enable_clr_op_in) begin
            st_nxt.enable = 1'b0;
         end
      end
      case (st_r.state)
         CIA_ST_RUN: begin
         end
         CIA_ST_ENTRY: begin
            st_nxt.cyc = 3'(st_r.cyc + 3'h1);
            case (st_r.cyc)
               3'h0: begin
                  // Low byte goes first
                  st_nxt.swr = '{1'b1, CIA_STACK_BASE | {4'h0, st_r.sp},
                                 st_r.ret_pc[7:0]}; // RULE_19
               end
               3'h1: begin
                  st_nxt.swr = '{1'b1, CIA_STACK_BASE | {4'h0, 4'(st_r.sp - 4'h1)},
                                 {4'h0, st_r.ret_pc[11:8]}};
                  st_nxt.sp = 4'(st_r.sp - CIA_SP_STEP); // RULE_20
                  // Step early: vector data trails its address by one cycle
                  st_nxt.vec_addr = 12'(st_r.vec_addr + 12'h1);
               end
               3'h2: begin
                  st_nxt.lo_byte = vec_rd_data_in;
               end
               3'h3: begin
                  st_nxt.pc_val = {vec_rd_data_in[3:0], st_r.lo_byte}; // RULE_22
               end
               default: begin
                  // Cleared only now, after stacking and vector fetch
                  st_nxt.enable = 1'b0; // RULE_03 RULE_09
                  st_nxt.pc_load = 1'b1; // RULE_05
                  st_nxt.state = CIA_ST_RUN;
               end
            endcase
         end
         CIA_ST_RET_LO: begin
            // Pop order reverses push order: high byte comes back first
            st_nxt.rd_addr = CIA_STACK_BASE | {4'h0, st_r.sp};
            st_nxt.state = CIA_ST_RET_HI; // RULE_06
         end
         CIA_ST_RET_HI: begin
            st_nxt.pc_val[11:8] = stack_rd_data_in[3:0];
            st_nxt.state = CIA_ST_RET_GO;
         end
         CIA_ST_RET_GO: begin
            st_nxt.pc_val[7:0] = stack_rd_data_in;
            st_nxt.enable = 1'b1; // RULE_06
            st_nxt.pc_load = 1'b1;
            st_nxt.state = CIA_ST_RUN;
         end
         default: st_nxt.state = CIA_ST_RUN;
      endcase
   end
   // The pc value is in place by the load pulse; RET_GO writes its low byte together with the pulse
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         // Enable, pending, source and strobes all come up clear
         st_r <= '{state: CIA_ST_RUN, sp: CIA_SP_RST, ret_pc: CIA_PC_RST,
                   vec_addr: CIA_VEC_TRAP, pc_val: CIA_PC_RST, default: '0}; // RULE_02
      end else begin
         st_r <= st_nxt;
      end
   end
   // ------------------------------------------------------------
   // Address former
   // ------------------------------------------------------------
   cia_addr_gen u_addr_gen (
      .clk_in(sys_clk_in),
      .rst_n_in(rst_n),
      .req_in(addr_req_in),
      .mem_ptr_in(mem_ptr_in),
      .pc_in(pc_in),
      .res_out(addr_res_out)
   );
   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign irq_enable_out = st_r.enable;
   assign pending_out = st_r.pend;
   assign busy_out = (st_r.state != CIA_ST_RUN);
   // Hold the core through entry and return, and in the cycle entry starts
   assign hold_core_out = busy_out || take; // RULE_04
   assign stack_ptr_out = st_r.sp;
   assign stack_wr_out = st_r.swr;
   assign stack_rd_addr_out = st_r.rd_addr;
   assign vec_addr_out = st_r.vec_addr;
   assign pc_load_out = st_r.pc_load;
   assign pc_load_val_out = st_r.pc_val;
   assign active_src_out = st_r.src;
endmodule
`default_nettype wire

//--- tb/cia_src_model.sv
// Request sources plus the stack and vector memories seen by the sequencer
`timescale 1ns/1ns
`default_nettype none
module cia_src_model
   import cia_pkg::*;
(
   input wire logic clk_in,
   input wire logic [2:0] fire_in,
   output logic [2:0] irq_out,
   input wire cia_stack_wr_t wr_in,
   input wire logic [7:0] rd_addr_in,
   input wire logic [11:0] vec_addr_in,
   output logic [7:0] rd_data_out,
   output logic [7:0] vec_data_out
);
   logic [7:0] mem [256];
   initial begin
      irq_out = 3'h0;
      rd_data_out = 8'h00;
      vec_data_out = 8'h00;
   end
   // Sources pulse once; latching them is left to the device
   always @(posedge clk_in) begin
      irq_out <= fire_in;
      if (wr_in.valid) begin
         mem[wr_in.addr] <= wr_in.data;
      end
      rd_data_out <= mem[rd_addr_in];
      vec_data_out <= vec_addr_in[7:0] + 8'h11;
   end
endmodule
`default_nettype wire

//--- tb/cia_core_irq_monitor.sv
// Port checker for the interrupt sequencer and address former
`timescale 1ns/1ns
`default_nettype none
module cia_core_irq_monitor
   import cia_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic wakeup_edge_irq_in,
   input wire logic timer_zero_irq_in,
   input wire logic timer_one_irq_in,
   input wire logic instr_done_in,
   input wire logic soft_trap_op_in,
   input wire logic irq_return_op_in,
   input wire logic enable_set_op_in,
   input wire logic enable_clr_op_in,
   input wire logic [11:0] pc_in,
   input wire cia_addr_req_t addr_req_in,
   input wire cia_addr_res_t addr_res_out,
   input wire logic irq_enable_out,
   input wire logic [3:0] pending_out,
   input wire logic busy_out,
   input wire logic hold_core_out,
   input wire logic [3:0] stack_ptr_out,
   input wire cia_stack_wr_t stack_wr_out,
   input wire logic pc_load_out,
   input wire logic [1:0] active_src_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   // ----------------
   // Helpers
   // ----------------
   logic take;
   logic [3:0] elig;
   logic [1:0] win;
   logic [11:0] cap_r;
   assign take = instr_done_in && hold_core_out && !busy_out && !irq_return_op_in;
   assign elig = {(pending_out[3:1] | {wakeup_edge_irq_in, timer_zero_irq_in, timer_one_irq_in})
      & {3{irq_enable_out}}, pending_out[0] | soft_trap_op_in};
   assign win = elig[3] ? 2'h3 : elig[2] ? 2'h2 : elig[1] ? 2'h1 : 2'h0;
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cap_r <= 12'h000;
      end else if (take) begin
         cap_r <= pc_in;
      end
   end
   // ----------------
   // Properties
   // ----------------
   property p_entry; take |=> busy_out [*5] ##1 pc_load_out; endproperty
   a_entry: assert property (p_entry) else $error("entry length wrong");
   property p_prio; take && !enable_set_op_in |=> active_src_out == $past(win); endproperty
   a_prio: assert property (p_prio) else $error("wrong winner");
   property p_mask;
      !irq_enable_out && !pending_out[0] && !soft_trap_op_in && !busy_out
         && !irq_return_op_in && !enable_set_op_in |-> !hold_core_out;
   endproperty
   a_mask: assert property (p_mask) else $error("masked entry");
   property p_pend; !irq_enable_out && timer_zero_irq_in && !enable_set_op_in |=> pending_out[2];
   endproperty
   a_pend: assert property (p_pend) else $error("request lost");
   property p_en_fall; $fell(irq_enable_out) |-> pc_load_out || $past(enable_clr_op_in); endproperty
   a_en_fall: assert property (p_en_fall) else $error("enable cleared early");
   property p_en_rise;
      $rose(irq_enable_out) |-> $past(enable_set_op_in) || $past(irq_return_op_in, 2)
         || $past(irq_return_op_in, 3) || $past(irq_return_op_in, 4) || $past(irq_return_op_in, 5);
   endproperty
   a_en_rise: assert property (p_en_rise) else $error("enable set without cause");
   property p_sp;
      $changed(stack_ptr_out) |-> stack_ptr_out == $past(stack_ptr_out) - 4'h2
         || stack_ptr_out == $past(stack_ptr_out) + 4'h2;
   endproperty
   a_sp: assert property (p_sp) else $error("stack pointer step wrong");
   property p_push_lo;
      stack_wr_out.valid && !$past(stack_wr_out.valid) |->
         stack_wr_out.data == cap_r[7:0] && stack_wr_out.addr == {4'h3, stack_ptr_out};
   endproperty
   a_push_lo: assert property (p_push_lo) else $error("first push wrong");
   property p_push_hi;
      stack_wr_out.valid && $past(stack_wr_out.valid) |->
         stack_wr_out.addr == $past(stack_wr_out.addr) - 8'h1
         && stack_wr_out.data[3:0] == cap_r[11:8];
   endproperty
   a_push_hi: assert property (p_push_hi) else $error("second push wrong");
   property p_direct;
      addr_req_in.mode == CIA_AM_DIRECT && addr_req_in.op == CIA_OP_OTHER |=>
         addr_res_out.legal && addr_res_out.addr == {4'h0, $past(addr_req_in.byte1)};
   endproperty
   a_direct: assert property (p_direct) else $error("direct address wrong");
   property p_immed;
      addr_req_in.mode == CIA_AM_IMMEDIATE && addr_req_in.op == CIA_OP_OTHER |=>
         addr_res_out.is_value && addr_res_out.value == $past(addr_req_in.byte1);
   endproperty
   a_immed: assert property (p_immed) else $error("immediate value wrong");
   c_take: cover property (take);
   c_nest: cover property (stack_ptr_out == 4'hb);
   c_prog: cover property (addr_res_out.legal && addr_res_out.prog_space);
endmodule
bind cia_core_irq cia_core_irq_monitor mon_u (.*);
`default_nettype wire

//--- tb/core_interrupt_and_addressing_bench.sv
// Self-checking bench for the interrupt sequencer and address former
`timescale 1ns/1ns
`default_nettype none
module core_interrupt_and_addressing_bench;
   import cia_pkg::*;
   logic sys_clk, rstn, done, trap, ret, eset, eclr;
   logic [2:0] fire, irq;
   logic [11:0] pc, ptr, vec_addr, load_val;
   logic [7:0] rd_data, vec_data, rd_addr;
   logic [3:0] pend, sp;
   logic [1:0] src;
   logic en, busy, hold, load;
   cia_addr_req_t areq;
   cia_addr_res_t ares;
   cia_stack_wr_t swr;
   int error_cnt = 0;
   int num_checks = 0;
   logic [11:0] vt [4] = '{CIA_VEC_WAKE, CIA_VEC_TMR0, CIA_VEC_TMR1, CIA_VEC_TRAP};
   logic [7:0] edge_b [4] = '{8'he1, 8'h20, 8'h21, 8'he0};
   cia_core_irq dut_u (.sys_clk_in(sys_clk), .rstn_in(rstn), .wakeup_edge_irq_in(irq[2]),
      .timer_zero_irq_in(irq[1]), .timer_one_irq_in(irq[0]), .instr_done_in(done),
      .soft_trap_op_in(trap), .irq_return_op_in(ret), .enable_set_op_in(eset),
      .enable_clr_op_in(eclr), .pc_in(pc), .mem_ptr_in(ptr), .stack_rd_data_in(rd_data),
      .vec_rd_data_in(vec_data), .addr_req_in(areq), .addr_res_out(ares), .irq_enable_out(en),
      .pending_out(pend), .busy_out(busy), .hold_core_out(hold), .stack_ptr_out(sp),
      .stack_wr_out(swr), .stack_rd_addr_out(rd_addr), .vec_addr_out(vec_addr),
      .pc_load_out(load), .pc_load_val_out(load_val), .active_src_out(src));
   cia_src_model src_u (.clk_in(sys_clk), .fire_in(fire), .irq_out(irq), .wr_in(swr),
      .rd_addr_in(rd_addr), .vec_addr_in(vec_addr), .rd_data_out(rd_data),
      .vec_data_out(vec_data));
   // ----------------
   // Tasks and expectations
   // ----------------
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic fail(input string s);
      error_cnt++;
      $display("unexpected at %0t: %s", $time, s);
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) fail($sformatf("value %h, want %h", got, exp));
   endtask
   task automatic chk_st(input logic e, input logic [3:0] s);
      num_checks++;
      if ({en, sp} !== {e, s}) fail($sformatf("enable/sp %b/%h", en, sp));
   endtask
   task automatic chk_res(input cia_mode_t m, input logic [12:0] e);
      logic [12:0] g;
      g = {ares.legal, ares.addr};
      if (m == CIA_AM_IMMEDIATE) g[11:0] = {4'h0, ares.value};
      if (m == CIA_AM_INHERENT) g[11:0] = {10'h0, ares.operand_bytes};
      if (ares.legal === 1'b0) g[11:0] = 12'h0;
      num_checks++;
      if (g !== e) fail($sformatf("mode %0d result %h, want %h", m, g, e));
   endtask
   // Ops are {done, trap, return, set, clear}
   task automatic step(input logic [4:0] o, input logic [2:0] f);
      {done, trap, ret, eset, eclr} = o;
      fire = f;
      tick();
      {done, trap, ret, eset, eclr} = 5'h0;
      fire = 3'h0;
      // Idle edge so a following step never re-raises a strobe in the same time step
      tick();
   endtask
   task automatic wait_load();
      int n;
      n = 0;
      while (load !== 1'b1 && n < 20) begin
         tick();
         n++;
      end
      if (n == 20) fail("no program counter load");
   endtask
   task automatic ret_chk(input logic [11:0] a, input logic [3:0] s);
      tick();
      step(5'b00100, 3'h0);
      wait_load();
      chk(load_val, a);
      tick();
      chk_st(1'b1, s);
   endtask
   function automatic logic [11:0] vexp(input logic [11:0] v);
      logic [7:0] lo, hi;
      lo = v[7:0] + 8'h11;
      hi = v[7:0] + 8'h12;
      return {hi[3:0], lo};
   endfunction
   function automatic logic [12:0] exp_res(input cia_addr_req_t q, input logic [11:0] p,
      input logic [11:0] x);
      logic [10:0] s;
      logic lg;
      int d;
      s = x[10:0] + {3'h0, q.byte1};
      d = int'($signed(q.byte1));
      case (q.op)
         CIA_OP_LESS_SKIP: lg = q.mode == CIA_AM_IMMEDIATE && q.ptr_dest;
         CIA_OP_ACC_WRITE: lg = q.mode inside {CIA_AM_DIRECT, CIA_AM_INDEXED, CIA_AM_INDIRECT};
         CIA_OP_FAR_BRANCH, CIA_OP_CALL: lg = q.mode inside {CIA_AM_INDEXED, CIA_AM_ABSOLUTE};
         CIA_OP_NEAR_BRANCH: lg = q.mode == CIA_AM_RELATIVE && d >= CIA_REL_MIN && d <= CIA_REL_MAX;
         default: lg = q.mode <= CIA_AM_INHERENT;
      endcase
      if (!lg) return 13'h0;
      case (q.mode)
         CIA_AM_INDEXED: return x[11] ? {2'b11, s} : {5'h10, s[7:0]};
         CIA_AM_INDIRECT: return {5'h10, x[7:0]};
         CIA_AM_DIRECT, CIA_AM_IMMEDIATE: return {5'h10, q.byte1};
         CIA_AM_INHERENT: return 13'h1000;
         CIA_AM_ABSOLUTE: return {2'b11, q.byte1[2:0], q.byte2};
         default: return {1'b1, p + {{4{q.byte1[7]}}, q.byte1}};
      endcase
   endfunction
   task automatic conclude();
      $display("checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ----------------
   // Clock, watchdog and sequence
   // ----------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      #100000;
      fail("watchdog expired");
      conclude();
   end
   initial begin
      void'($urandom(32'h650fb92e));
      {rstn, done, trap, ret, eset, eclr, fire} = 9'h0;
      pc = 12'h800;
      ptr = 12'h000;
      areq = '0;
      repeat (3) @(posedge sys_clk);
      #1 rstn = 1'b1;
      repeat (4) tick();
      chk_st(1'b0, 4'hf);
      step(5'h0, 3'b001);
      tick();
      step(5'b10000, 3'h0);
      repeat (3) tick();
      chk({8'h0, pend}, 12'h002);
      chk({11'h0, busy}, 12'h000);
      pc = 12'h9a5;
      step(5'b11000, 3'h0);
      wait_load();
      chk(load_val, vexp(CIA_VEC_TRAP));
      tick();
      chk_st(1'b0, 4'hd);
      ret_chk(12'h9a5, 4'hf);
      step(5'b10000, 3'h0);
      wait_load();
      chk(load_val, vexp(CIA_VEC_TMR1));
      ret_chk(12'h9a5, 4'hf);
      pc = 12'h8c3;
      step(5'b01000, 3'b111);
      repeat (4) tick();
      chk({11'h0, hold}, 12'h000);
      for (int i = 0; i < 4; i++) begin
         step(5'b10000, 3'h0);
         wait_load();
         chk(load_val, vexp(vt[i]));
         ret_chk(12'h8c3, 4'hf);
      end
      pc = 12'h811;
      step(5'b11000, 3'h0);
      wait_load();
      tick();
      step(5'b00010, 3'b010);
      pc = 12'h8f0;
      step(5'b10000, 3'h0);
      wait_load();
      chk(load_val, vexp(CIA_VEC_TMR0));
      tick();
      chk_st(1'b0, 4'hb);
      ret_chk(12'h8f0, 4'hd);
      ret_chk(12'h811, 4'hf);
      step(5'b00001, 3'h0);
      chk_st(1'b0, 4'hf);
      for (int i = 0; i < 300; i++) begin
         areq.op = cia_op_t'($urandom_range(5));
         areq.mode = cia_mode_t'($urandom_range(6));
         areq.ptr_dest = (areq.op == CIA_OP_LESS_SKIP) ? 1'($urandom_range(1)) : 1'b0;
         areq.byte1 = 8'($urandom);
         areq.byte2 = 8'($urandom);
         if (i < 4) begin
            areq.op = CIA_OP_NEAR_BRANCH;
            areq.mode = CIA_AM_RELATIVE;
            areq.byte1 = edge_b[i];
         end
         pc = 12'($urandom);
         ptr = 12'($urandom);
         if (areq.mode == CIA_AM_INDIRECT) ptr[11] = 1'b0;
         tick();
         chk_res(areq.mode, exp_res(areq, pc, ptr));
      end
      conclude();
   end
endmodule
`default_nettype wire
